// file: hdl/edsc_status_collector.sv
`timescale 1ns/10ps
`include "edsc_defs.svh"
// Functional notes
// - writing one to a clearable status bit clears it
// - writing zero to a status bit leaves it unchanged
// - mac summary bit 22 is read-only; write-one does not clear it
// - mac summary bit follows mac source, clearing when the source clears
// - permission register masks each status bit's interrupt contribution
// - all status interrupts drive the single event interrupt line
// - bits 31 and 29..27 read zero; software writes zero there
// - bit 30 set on write-back done, only when write-back select is 1
// - bit 26 set when mac aborts a transmission
// - bit 25 set when mac aborts a reception
// - bit 24 set when receive fifo frame counter overflows
// - bit 23 set when dma detects an illegal address
// - address error halts tx and rx until software reset via mode register
module edsc_status_collector
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        writeback_done_evt,
  input  wire logic        tx_abort_evt,
  input  wire logic        rx_abort_evt,
  input  wire logic        rx_frame_count_ovf_evt,
  input  wire logic        illegal_address_evt,
  input  wire logic        mac_status_pending,
  output logic             ether_event_irq,
  output logic             dma_halt,
  output logic             soft_reset_pulse
);

  logic [31:0]                   status_q;
  logic [31:0]                   status_d;
  logic [31:0]                   permit_q;
  logic                          tx_wb_sel_q;
  logic                          halt_q;
  logic                          soft_rst_q;
  logic [31:0]                   rdata_q;
  logic                          irq_q;
  edsc_pkg::edsc_bus_state_t     bus_q;
  logic [31:0]                   be_mask;
  logic [31:0]                   wr_bits;
  logic [31:0]                   set_bits;
  logic [31:0]                   clr_bits;
  logic                          access;
  logic                          wr_take;
  logic                          rd_take;
  logic                          sel_status;
  logic                          sel_permit;
  logic                          sel_clear;
  logic                          sel_ctrl;
  logic                          ctrl_take;
  logic                          soft_rst_req;
  logic                          waitreq_q;
  edsc_pkg::edsc_bus_state_t     bus_d;
  logic [4:0]                    evt_vec;
  logic [31:0]                   pend_bits;
  logic [31:0]                   rdata_d;

  // masks as constants so the generate loops can pick single bits
  localparam logic [31:0] CLR_MASK     = `EDSC_CLR_MASK;
  localparam logic [31:0] IMPL_MASK    = `EDSC_IMPL_MASK;
  localparam logic [31:0] STATUS_RESET = `EDSC_STATUS_RESET;
  localparam logic [31:0] PERMIT_RESET = `EDSC_PERMIT_RESET;
  localparam int          EVT_COUNT    = 5;
  // status position fed by each event, index 0 first
  localparam int          EVT_POS [EVT_COUNT] = '{`EDSC_BIT_WB_DONE,
                                                  `EDSC_BIT_TX_ABORT,
                                                  `EDSC_BIT_RX_ABORT,
                                                  `EDSC_BIT_RFC_OVF,
                                                  `EDSC_BIT_ILL_ADDR};

  // single-cycle wait: writes taken in the ack state, reads in the idle state
  assign access  = avs_read | avs_write;
  assign wr_take = avs_write & (bus_q == edsc_pkg::EDSC_ACK);
  assign rd_take = avs_read & (bus_q == edsc_pkg::EDSC_IDLE);

  assign sel_status   = (avs_address == `EDSC_OFF_STATUS);
  assign sel_permit   = (avs_address == `EDSC_OFF_PERMIT);
  assign sel_clear    = (avs_address == `EDSC_OFF_CLEAR);
  assign sel_ctrl     = (avs_address == `EDSC_OFF_CTRL);
  // ctrl fields all live in lane 0; other lanes of that word are ignored
  assign ctrl_take    = wr_take & sel_ctrl & avs_byteenable[0];
  assign soft_rst_req = ctrl_take & avs_writedata[`EDSC_BIT_SOFT_RST];

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_lane
      assign be_mask[8*g +: 8] = {8{avs_byteenable[g]}};
    end
  endgenerate

  assign wr_bits = avs_writedata & be_mask;

  // write-back events count only while the select bit is set
  assign evt_vec[0] = writeback_done_evt & tx_wb_sel_q;
  assign evt_vec[1] = tx_abort_evt;
  assign evt_vec[2] = rx_abort_evt;
  assign evt_vec[3] = rx_frame_count_ovf_evt;
  assign evt_vec[4] = illegal_address_evt;

  always_comb
  begin
    set_bits = 32'h0000_0000;
    for (int e = 0; e < EVT_COUNT; e = e + 1)
      set_bits[EVT_POS[e]] = evt_vec[e];
  end

  // only ones clear; the summary bit is outside the clear mask
  always_comb
  begin
    clr_bits = 32'h0000_0000;
    if (wr_take && (sel_status || sel_clear))
      clr_bits = wr_bits & `EDSC_CLR_MASK;
  end

  // one flop per bit; reserved positions hold zero
  generate
    for (g = 0; g < 32; g = g + 1)
    begin : g_status
      if (g == `EDSC_BIT_MAC_SUM)
      begin : g_mirror
        // no clear path: drops only once the mac source drops
        assign status_d[g] = mac_status_pending;
      end
      else if (CLR_MASK[g])
      begin : g_sticky
        // set wins over a clear in the same cycle
        assign status_d[g] = (status_q[g] & ~clr_bits[g]) | set_bits[g];
      end
      else
      begin : g_rsvd
        assign status_d[g] = 1'b0;
      end

      always_ff @(posedge ref_clk or posedge sys_rst)
      begin
        if (sys_rst)
          status_q[g] <= STATUS_RESET[g];
        else if (clk_en)
          status_q[g] <= status_d[g];
      end
    end
  endgenerate

  // byte lanes gate each permit bit on its own
  generate
    for (g = 0; g < 32; g = g + 1)
    begin : g_permit
      always_ff @(posedge ref_clk or posedge sys_rst)
      begin
        if (sys_rst)
          permit_q[g] <= PERMIT_RESET[g];
        else if (clk_en && wr_take && sel_permit && avs_byteenable[g / 8])
          permit_q[g] <= avs_writedata[g] & IMPL_MASK[g];
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      tx_wb_sel_q <= 1'b0;
    else if (clk_en && ctrl_take)
      tx_wb_sel_q <= avs_writedata[`EDSC_BIT_TX_WB_SEL];
  end

  // a frozen clock enable stretches the pulse with everything else
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      soft_rst_q <= 1'b0;
    else if (clk_en)
      soft_rst_q <= soft_rst_req;
  end

  // halt holds until software reset; a new error in that cycle wins
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      halt_q <= 1'b0;
    else if (clk_en)
    begin
      if (illegal_address_evt)
        halt_q <= 1'b1;
      else if (soft_rst_req)
        halt_q <= 1'b0;
    end
  end

  assign pend_bits = status_d & permit_q;

  // registered irq: built from next status, so it changes with status, keeps output glitch-free
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_q <= 1'b0;
    else if (clk_en)
      irq_q <= |pend_bits;
  end

  always_comb
  begin
    bus_d = bus_q;
    case (bus_q)
      edsc_pkg::EDSC_IDLE:
        if (access)
          bus_d = edsc_pkg::EDSC_ACK;
      edsc_pkg::EDSC_ACK:
        bus_d = edsc_pkg::EDSC_IDLE;
      default:
        bus_d = edsc_pkg::EDSC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      bus_q <= edsc_pkg::EDSC_IDLE;
    else if (clk_en)
      bus_q <= bus_d;
  end

  // waitrequest from its own flop so the bus never sees decode glitches
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      waitreq_q <= 1'b1;
    else if (clk_en)
    begin
      if (bus_d == edsc_pkg::EDSC_ACK)
        waitreq_q <= 1'b0;
      else
        waitreq_q <= 1'b1;
    end
  end

  // read mux; the clear register is write-only and reads zero
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case (avs_address)
      `EDSC_OFF_STATUS: rdata_d = status_q & `EDSC_IMPL_MASK;
      `EDSC_OFF_PERMIT: rdata_d = permit_q;
      `EDSC_OFF_CTRL:   rdata_d = {30'h0000_0000, halt_q, tx_wb_sel_q};
      default:          rdata_d = 32'h0000_0000;
    endcase
  end

  // read data prepared while waitrequest is still high
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_q <= 32'h0000_0000;
    else if (clk_en && rd_take)
      rdata_q <= rdata_d;
  end

  assign avs_readdata     = rdata_q;
  assign avs_waitrequest  = waitreq_q;
  assign ether_event_irq  = irq_q;
  assign dma_halt         = halt_q;
  assign soft_reset_pulse = soft_rst_q;

endmodule

// file: hdl/edsc_defs.svh
`ifndef EDSC_DEFS_SVH
`define EDSC_DEFS_SVH

// register word offsets (byte addresses)
`define EDSC_OFF_STATUS      4'h0
`define EDSC_OFF_PERMIT      4'h4
`define EDSC_OFF_CLEAR       4'h8
`define EDSC_OFF_CTRL        4'hC

// status bit positions
`define EDSC_BIT_WB_DONE     30
`define EDSC_BIT_TX_ABORT    26
`define EDSC_BIT_RX_ABORT    25
`define EDSC_BIT_RFC_OVF     24
`define EDSC_BIT_ILL_ADDR    23
`define EDSC_BIT_MAC_SUM     22

// control register bits
`define EDSC_BIT_TX_WB_SEL   0
`define EDSC_BIT_SOFT_RST    1

// writable status bits: 30, 26..23
`define EDSC_CLR_MASK        32'h4780_0000
// bits implemented in status/permit: 30, 26..22
`define EDSC_IMPL_MASK       32'h47C0_0000
`define EDSC_STATUS_RESET    32'h0000_0000
`define EDSC_PERMIT_RESET    32'h0000_0000

`endif

// file: hdl/edsc_pkg.sv
package edsc_pkg;
  typedef enum logic [1:0] {
    EDSC_IDLE = 2'b00,
    EDSC_ACK  = 2'b01
  } edsc_bus_state_t;
endpackage

// file: verif/edsc_event_src.sv
`timescale 1ns/10ps
module edsc_event_src
(
  input  wire logic       ref_clk,
  input  wire logic [4:0] fire,
  output logic      [4:0] evt
);
  // strobes last one cycle, as the engine and mac emit them
  initial evt = 5'h00;
  always @(posedge ref_clk)
    evt <= fire;
endmodule

// file: verif/edsc_sva.sv
`timescale 1ns/10ps
module edsc_sva
(
  input wire logic ref_clk, sys_rst, clk_en, avs_read, avs_write, avs_waitrequest,
  input wire logic illegal_address_evt, mac_status_pending, ether_event_irq,
  input wire logic dma_halt, soft_reset_pulse,
  input wire logic [3:0] avs_address,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata, avs_readdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire sr = avs_write && !avs_waitrequest && clk_en && avs_address == 4'hC &&
    avs_byteenable[0] && avs_writedata[1];
  a_wait_one: assert property (clk_en && avs_waitrequest && (avs_read || avs_write)
    |=> !avs_waitrequest) else $error("no answer");
  a_wait_single: assert property (clk_en && !avs_waitrequest |=> avs_waitrequest)
    else $error("long ack");
  a_halt_set: assert property (clk_en && illegal_address_evt && !sr |=> dma_halt)
    else $error("no halt");
  a_halt_clear: assert property (sr && !illegal_address_evt |=> !dma_halt)
    else $error("halt stuck");
  a_pulse_cause: assert property ($rose(soft_reset_pulse) |-> $past(sr))
    else $error("stray pulse");
  a_pulse_short: assert property (clk_en && soft_reset_pulse |=> !soft_reset_pulse)
    else $error("long pulse");
  a_rsvd_zero: assert property (avs_readdata[31] == 1'b0 && avs_readdata[29:27] == 3'b000)
    else $error("reserved bits set");
  a_irq_hold: assert property (clk_en && ether_event_irq && avs_waitrequest
    && $stable(mac_status_pending) |=> ether_event_irq) else $error("irq lost");
  a_rdata_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("rdata moved");
endmodule
bind edsc_status_collector edsc_sva u_edsc_sva (.*);

// file: verif/edsc_status_collector_test.sv
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module edsc_status_collector_test;
  typedef struct { logic [4:0] f; logic [31:0] p; logic irq; } edsc_row_t;
  edsc_row_t rows [6] = '{'{5'h10, 32'h4000_0000, 1'b1}, '{5'h08, 32'h0, 1'b0},
    '{5'h04, 32'h0200_0000, 1'b1}, '{5'h02, 32'h0200_0000, 1'b0},
    '{5'h01, 32'h0080_0000, 1'b1}, '{5'h1F, 32'h47C0_0000, 1'b1}};
  logic        ref_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, mac = 1'b0;
  logic        avs_waitrequest, irq, halt, pulse;
  logic        en = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [4:0]  fire = 5'h00, evt;
  int          mismatches = 0, cmp_count = 0;
  always #4 ref_clk = ~ref_clk;
  edsc_event_src u_edsc_event_src (.ref_clk(ref_clk), .fire(fire), .evt(evt));
  edsc_status_collector u_edsc_status_collector (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .clk_en(en), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .writeback_done_evt(evt[4]), .tx_abort_evt(evt[3]),
    .rx_abort_evt(evt[2]), .rx_frame_count_ovf_evt(evt[1]), .illegal_address_evt(evt[0]),
    .mac_status_pending(mac), .ether_event_irq(irq), .dma_halt(halt), .soft_reset_pulse(pulse));
  function automatic logic [31:0] st(input logic [4:0] f);
    return {1'b0, f[4], 3'b000, f[3:0], 23'h0};
  endfunction
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic pulse_evt(input logic [4:0] f);
    @(posedge ref_clk);
    fire <= f;
    @(posedge ref_clk);
    fire <= 5'h00;
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    `CHK(avs_waitrequest, 1'b1)
    bus(1'b0, 4'h4, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b1, 4'hC, 32'h1);
    foreach (rows[i])
    begin
      bus(1'b1, 4'h4, rows[i].p);
      pulse_evt(rows[i].f);
      bus(1'b0, 4'h0, 32'h0);
      `CHK(q, st(rows[i].f))
      `CHK(irq, rows[i].irq)
      bus(1'b1, 4'h8, 32'h4780_0000);
      bus(1'b0, 4'h0, 32'h0);
      `CHK(q, 32'h0)
    end
    bus(1'b1, 4'hC, 32'h0);
    pulse_evt(5'h10);
    bus(1'b0, 4'h0, 32'h0);
    `CHK(q, 32'h0)
    mac <= 1'b1;
    pulse_evt(5'h08);
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b0, 4'h0, 32'h0);
    `CHK(q, 32'h0440_0000)
    bus(1'b1, 4'h0, 32'h47C0_0000);
    bus(1'b0, 4'h0, 32'h0);
    `CHK(q, 32'h0040_0000)
    mac <= 1'b0;
    bus(1'b0, 4'h0, 32'h0);
    `CHK(q, 32'h0)
    `CHK(halt, 1'b1)
    bus(1'b1, 4'hC, 32'h2);
    @(negedge ref_clk);
    `CHK(pulse, 1'b1)
    `CHK(halt, 1'b0)
    bus(1'b0, 4'h2, 32'h0);
    `CHK(q, 32'h0)
    @(posedge ref_clk);
    en <= 1'b0;
    pulse_evt(5'h08);
    @(posedge ref_clk);
    en <= 1'b1;
    bus(1'b0, 4'h0, 32'h0);
    `CHK(q, 32'h0)
    complete_run;
  end
  initial
  begin
    repeat (2000) @(posedge ref_clk);
    mismatches++;
    complete_run;
  end
endmodule
